/* design/motion_timer_pwm_capture.sv */
// Purpose: Motion control unit core: address decode, timers, capture queues, PWM pairs.
// Assumes: Core bus is synchronous, 16-bit, single-cycle strobes.
// Notes: Read data is registered one cycle after the strobe.
`timescale 1ns/1ps
`include "motion_timer_map.svh"
module motion_timer_pwm_capture #(
  parameter int NUM_TIMERS = 3,
  parameter int NUM_CAPTURE = 4,
  parameter int NUM_PWM = 3,
  parameter int DB_WIDTH = 8
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [15:0] ADDR,
  input wire logic RD_STROBE,
  input wire logic DIRECTION_IN,
  input wire logic [NUM_TIMERS-1:0] TIMER_RUN,
  input motion_timer_pkg::count_mode_type TIMER_MODE [NUM_TIMERS],
  input wire logic [NUM_CAPTURE-1:0] CAPTURE_EVENT,
  input wire logic [NUM_PWM-1:0] COMPARE_RAW,
  input motion_timer_pkg::action_type PWM_ACTION [NUM_PWM],
  input wire logic DEADBAND_ON,
  input wire logic [DB_WIDTH-1:0] DEADBAND_LEN,
  output logic UNIT_SELECT,
  output logic [15:0] READ_DATA,
  output logic [NUM_TIMERS*16-1:0] TIMER_COUNT,
  output logic [NUM_PWM-1:0] PWM_A,
  output logic [NUM_PWM-1:0] PWM_B
);
  import motion_timer_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic in_unit(input logic [15:0] a);
    // Full 16-bit compare: upper aliases fall outside
    in_unit = (a >= `UNIT_ADDR_LOW) && (a <= `UNIT_ADDR_HIGH);
  endfunction

  wire hit = RD_STROBE && in_unit(ADDR);
  wire status_hit = hit && (ADDR == `CAPTURE_STATUS_ADDR);
  logic [NUM_CAPTURE-1:0] pop;

  // ----------------------------------------
  // General purpose timers
  // ----------------------------------------
  logic [15:0] count_reg [NUM_TIMERS];
  genvar t;
  generate
    for (t = 0; t < NUM_TIMERS; t++) begin : g_timer
      wire wraps = (TIMER_MODE[t] == MODE_QUADRATURE) ||
                   ((TIMER_MODE[t] == MODE_DIRECTION) && (t == 1));
      wire at_max = count_reg[t] == `TIMER_MAX;
      wire at_zero = count_reg[t] == `TIMER_ZERO;
      logic [15:0] count_next;
      always_comb begin
        count_next = count_reg[t];
        if (TIMER_RUN[t] && TIMER_MODE[t] != MODE_HOLD) begin
          if (TIMER_MODE[t] == MODE_FREE) begin
            count_next = count_reg[t] + 16'h0001;
          end else if (DIRECTION_IN) begin
            if (!at_max || wraps) begin
              count_next = count_reg[t] + 16'h0001;
            end
          end else if (!at_zero || wraps) begin
            count_next = count_reg[t] - 16'h0001;
          end
        end
      end
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          count_reg[t] <= `TIMER_ZERO;
        end else begin
          count_reg[t] <= count_next;
        end
      end
      assign TIMER_COUNT[t*16 +: 16] = count_reg[t];
      chk_wrap_down: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (wraps && TIMER_RUN[t] && !DIRECTION_IN && at_zero) |=> (count_reg[t] == `TIMER_MAX))
        else $error("down wrap missed");
      chk_wrap_up: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (wraps && TIMER_RUN[t] && DIRECTION_IN && at_max) |=> (count_reg[t] == `TIMER_ZERO))
        else $error("up wrap missed");
      chk_hold_sat: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (!wraps && TIMER_MODE[t] == MODE_DIRECTION && !DIRECTION_IN && at_zero) |=> at_zero)
        else $error("saturation lost");
    end
  endgenerate

  // ----------------------------------------
  // Capture queues, two entries each
  // ----------------------------------------
  logic [1:0] status_reg [NUM_CAPTURE];
  logic [15:0] entry_reg [NUM_CAPTURE][2];
  genvar c;
  generate
    for (c = 0; c < NUM_CAPTURE; c++) begin : g_capture
      assign pop[c] = hit && (ADDR == `CAPTURE_DATA_ADDR0 + 16'(c));
      wire cap = CAPTURE_EVENT[c];
      logic [1:0] status_next;
      always_comb begin
        status_next = status_reg[c];
        case (status_reg[c])
          `QUEUE_EMPTY: status_next = cap ? `QUEUE_ONE : `QUEUE_EMPTY;
          `QUEUE_ONE: status_next = (cap && !pop[c]) ? `QUEUE_TWO : (pop[c] && !cap ? `QUEUE_EMPTY : `QUEUE_ONE);
          `QUEUE_TWO: status_next = (cap && !pop[c]) ? `QUEUE_OVER : (pop[c] && !cap ? `QUEUE_ONE : `QUEUE_TWO);
          default: status_next = pop[c] ? (cap ? `QUEUE_TWO : `QUEUE_ONE) : `QUEUE_OVER;
        endcase
      end
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          status_reg[c] <= `QUEUE_EMPTY;
          entry_reg[c][0] <= 16'h0000;
          entry_reg[c][1] <= 16'h0000;
        end else begin
          status_reg[c] <= status_next;
          // Entry 0 is the oldest; a pop shifts entry 1 down before any new capture lands
          if (pop[c] && cap) begin
            entry_reg[c][0] <= (status_reg[c] <= `QUEUE_ONE) ? count_reg[0] : entry_reg[c][1];
            entry_reg[c][1] <= count_reg[0];
          end else if (pop[c]) begin
            entry_reg[c][0] <= entry_reg[c][1];
          end else if (cap) begin
            if (status_reg[c] == `QUEUE_EMPTY) begin
              entry_reg[c][0] <= count_reg[0];
            end else begin
              entry_reg[c][1] <= count_reg[0];
            end
          end
        end
      end
      chk_coincide_keep: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (status_reg[c] == `QUEUE_OVER && cap && pop[c]) |=> (status_reg[c] == `QUEUE_TWO))
        else $error("second capture lost");
      chk_second_entry: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (status_reg[c] == `QUEUE_TWO && pop[c] && !cap) |=> (entry_reg[c][0] == $past(entry_reg[c][1])))
        else $error("second entry not presented");
    end
  endgenerate

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [15:0] status_word;
  logic [15:0] pop_word;
  always_comb begin
    status_word = 16'h0000;
    pop_word = 16'h0000;
    for (int i = 0; i < NUM_CAPTURE; i++) begin
      status_word[`CAPTURE_STATUS_LSB + 2*i +: 2] = status_reg[i];
      if (pop[i]) begin
        pop_word = entry_reg[i][0];
      end
    end
  end
  wire [15:0] timer_word = (ADDR >= `TIMER_COUNT_ADDR0 && ADDR < `TIMER_COUNT_ADDR0 + 16'(NUM_TIMERS)) ?
    count_reg[2'(ADDR - `TIMER_COUNT_ADDR0)] : 16'h0000;
  wire [15:0] read_next = status_hit ? status_word : (|pop ? pop_word : timer_word);

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      UNIT_SELECT <= 1'b0;
      READ_DATA <= 16'h0000;
    end else begin
      UNIT_SELECT <= hit;
      READ_DATA <= hit ? read_next : 16'h0000;
    end
  end
  chk_alias_reject: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (RD_STROBE && ADDR[15:12] == 4'hF) |=> !UNIT_SELECT) else $error("alias decoded");
  chk_window_accept: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (RD_STROBE && ADDR >= 16'h7400 && ADDR <= 16'h7434) |=> UNIT_SELECT) else $error("window access missed");

  // ----------------------------------------
  // PWM pairs
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < NUM_PWM; p++) begin : g_pwm
      deadband_output #(.DB_WIDTH(DB_WIDTH)) u_pair (
        .clock(CLOCK),
        .rst_n(RST_N),
        .compare_raw(COMPARE_RAW[p]),
        .action(PWM_ACTION[p]),
        .deadband_on(DEADBAND_ON),
        .deadband_len(DEADBAND_LEN),
        .out_a(PWM_A[p]),
        .out_b(PWM_B[p])
      );
    end
  endgenerate
endmodule

/* pkg/motion_timer_map.svh */
// Purpose: Constants for the motion control unit: address window, capture status layout, timer limits.
// Assumes: 16-bit data-space addresses and 16-bit data words.
// Notes: Offsets and counts as macros; types live in motion_timer_pkg.
`ifndef MOTION_TIMER_MAP_SVH
`define MOTION_TIMER_MAP_SVH
`define UNIT_ADDR_LOW 16'h7400
`define UNIT_ADDR_HIGH 16'h7434
`define CAPTURE_STATUS_ADDR 16'h7422
`define CAPTURE_STATUS_LSB 8
`define CAPTURE_DATA_ADDR0 16'h7423
`define TIMER_COUNT_ADDR0 16'h7401
`define TIMER_MAX 16'hFFFF
`define TIMER_ZERO 16'h0000
`define QUEUE_EMPTY 2'h0
`define QUEUE_ONE 2'h1
`define QUEUE_TWO 2'h2
`define QUEUE_OVER 2'h3
`define DEADBAND_RESET 8'h00
`endif

/* pkg/motion_timer_pkg.sv */
// Purpose: Types for the motion control unit.
// Assumes: Nothing beyond the map header.
// Notes: Output actions and timer count modes.
package motion_timer_pkg;
  typedef enum logic [1:0] {FORCE_LOW, ACTIVE_LOW, ACTIVE_HIGH, FORCE_HIGH} action_type;
  typedef enum logic [1:0] {MODE_HOLD, MODE_DIRECTION, MODE_QUADRATURE, MODE_FREE} count_mode_type;
endpackage

/* design/deadband_output.sv */
// Purpose: One PWM channel pair with action control and dead-band delay.
// Assumes: Raw compare state arrives one bit per cycle.
// Notes: Dead-band restarts on every edge of the raw signal.
`timescale 1ns/1ps
`include "motion_timer_map.svh"
module deadband_output #(
  parameter int DB_WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic compare_raw,
  input motion_timer_pkg::action_type action,
  input wire logic deadband_on,
  input wire logic [DB_WIDTH-1:0] deadband_len,
  output logic out_a,
  output logic out_b
);
  import motion_timer_pkg::*;
  logic raw_reg;
  logic [DB_WIDTH-1:0] db_reg;
  logic [DB_WIDTH-1:0] db_next;
  logic forced;
  logic active_level;
  logic db_busy;
  logic raw_edge;
  // Active level is recomputed from the live raw state, so leaving a force always lands correctly
  assign forced = (action == FORCE_LOW) || (action == FORCE_HIGH);
  assign active_level = (action == ACTIVE_LOW) ? ~compare_raw : compare_raw;
  assign raw_edge = compare_raw != raw_reg;
  // The edge cycle itself counts as dead time, so no output rises before the delay has run
  assign db_busy = deadband_on && (raw_edge ? (deadband_len != '0) : (db_reg > DB_WIDTH'(1)));
  // A short pulse restarts the counter on its falling edge too: both outputs stay off, no glitch
  assign db_next = raw_edge ? deadband_len : (db_reg != '0 ? db_reg - 1'b1 : db_reg);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      raw_reg <= 1'b0;
      db_reg <= DB_WIDTH'(`DEADBAND_RESET);
      out_a <= 1'b0;
      out_b <= 1'b0;
    end else begin
      raw_reg <= compare_raw;
      db_reg <= db_next;
      if (forced) begin
        out_a <= (action == FORCE_HIGH);
        out_b <= (action == FORCE_HIGH);
      end else begin
        out_a <= db_busy ? 1'b0 : active_level;
        out_b <= db_busy ? 1'b0 : ~active_level;
      end
    end
  end
  chk_force_follow: assert property (@(posedge clock) disable iff (!rst_n)
    (action == FORCE_HIGH) |=> (out_a && out_b)) else $error("forced high not applied");
  chk_deadband_gap: assert property (@(posedge clock) disable iff (!rst_n)
    (!forced && db_busy) |=> (!out_a && !out_b)) else $error("output during dead-band");
endmodule

/* verif/core_bus_model.sv */
// Purpose: Processor core model issuing data-space read strobes.
// Assumes: Called at a falling edge of the clock.
// Notes: Address is inverted while no strobe is out.
`timescale 1ns/1ps
module core_bus_model (
  input wire logic clock,
  output logic [15:0] addr,
  output logic rd_strobe
);
  initial begin
    addr = 16'h0000;
    rd_strobe = 1'b0;
  end
  // Keep the strobe up when another read follows at once
  task automatic issue(input logic [15:0] a, input bit more);
    addr = a;
    rd_strobe = 1'b1;
    @(negedge clock);
    if (!more) begin
      rd_strobe = 1'b0;
      addr = ~a;
    end
  endtask
endmodule

/* verif/motion_timer_pwm_capture_tb.sv */
// Purpose: Self-checking bench for the motion control unit.
// Assumes: Inputs change at the falling edge.
// Notes: Bus results are matched against a queue of expectations.
`timescale 1ns/1ps
`include "motion_timer_map.svh"
module motion_timer_pwm_capture_tb;
  import motion_timer_pkg::*;
  logic CLOCK = 1'b0, RST_N = 1'b0, DIRECTION_IN = 1'b0, DEADBAND_ON = 1'b1, UNIT_SELECT, pend = 1'b0;
  logic [15:0] ADDR, READ_DATA, r = 16'h0030;
  logic RD_STROBE;
  logic [2:0] TIMER_RUN = 3'h0, COMPARE_RAW = 3'h5, PWM_A, PWM_B, hi;
  logic [3:0] CAPTURE_EVENT = 4'h0;
  logic [7:0] DEADBAND_LEN = 8'h04;
  logic [47:0] TIMER_COUNT;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  count_mode_type tmode [3] = '{MODE_HOLD, MODE_HOLD, MODE_HOLD};
  action_type act [3] = '{FORCE_LOW, FORCE_LOW, FORCE_LOW};
  int n_mismatch = 0, n_compared = 0;
  always #5 CLOCK = ~CLOCK;
  core_bus_model core_bus_model_i (.clock(CLOCK), .addr(ADDR), .rd_strobe(RD_STROBE));
  motion_timer_pwm_capture motion_timer_pwm_capture_i (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR),
    .RD_STROBE(RD_STROBE), .DIRECTION_IN(DIRECTION_IN), .TIMER_RUN(TIMER_RUN), .TIMER_MODE(tmode),
    .CAPTURE_EVENT(CAPTURE_EVENT), .COMPARE_RAW(COMPARE_RAW), .PWM_ACTION(act), .DEADBAND_ON(DEADBAND_ON),
    .DEADBAND_LEN(DEADBAND_LEN), .UNIT_SELECT(UNIT_SELECT), .READ_DATA(READ_DATA),
    .TIMER_COUNT(TIMER_COUNT), .PWM_A(PWM_A), .PWM_B(PWM_B));
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always @(posedge CLOCK) pend <= RD_STROBE;
  always @(negedge CLOCK) begin
    if (pend) begin
      e = exp_q.pop_front();
      check({15'h0000, UNIT_SELECT}, {15'h0000, e[32]});
      check(READ_DATA & e[15:0], e[31:16]);
    end
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic rd(input logic [15:0] a, input logic [15:0] d, input logic [15:0] m, input bit more);
    logic sel;
    sel = (a >= `UNIT_ADDR_LOW) && (a <= `UNIT_ADDR_HIGH);
    exp_q.push_back(sel ? {1'b1, d & m, m} : {1'b0, 16'h0000, 16'hFFFF});
    core_bus_model_i.issue(a, more);
  endtask
  task automatic rd_timers(input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] e2);
    check(TIMER_COUNT[15:0], e0);
    check(TIMER_COUNT[31:16], e1);
    check(TIMER_COUNT[47:32], e2);
    rd(`TIMER_COUNT_ADDR0, e0, 16'hFFFF, 1);
    rd(`TIMER_COUNT_ADDR0 + 16'h0001, e1, 16'hFFFF, 1);
    rd(`TIMER_COUNT_ADDR0 + 16'h0002, e2, 16'hFFFF, 0);
  endtask
  task automatic run(input int n, input logic dir, input count_mode_type m);
    tmode = '{m, m, m};
    DIRECTION_IN = dir;
    TIMER_RUN = 3'h7;
    repeat (n) @(negedge CLOCK);
    TIMER_RUN = 3'h0;
  endtask
  task automatic cap(input logic [3:0] m);
    CAPTURE_EVENT = m;
    @(negedge CLOCK);
    CAPTURE_EVENT = 4'h0;
  endtask
  logic [15:0] addrs [12] = '{16'h7400, 16'h7434, 16'h7435, 16'h73FF, 16'hF400, 16'hF434,
                              16'hF600, 16'hF63F, 16'hFC00, 16'hFC3F, 16'hFE00, 16'hFE3F};
  initial begin
    #50000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (5) @(negedge CLOCK);
    RST_N = 1'b1;
    foreach (addrs[i]) rd(addrs[i], 16'h0000, 16'h0000, i != 11);
    $display("test decode done");
    run(1, 1'b0, MODE_DIRECTION);
    rd_timers(16'h0000, 16'hFFFF, 16'h0000);
    run(2, 1'b0, MODE_QUADRATURE);
    rd_timers(16'hFFFE, 16'hFFFD, 16'hFFFE);
    run(3, 1'b1, MODE_DIRECTION);
    rd_timers(16'hFFFF, 16'h0000, 16'hFFFF);
    run(2, 1'b0, MODE_DIRECTION);
    rd_timers(16'hFFFD, 16'hFFFE, 16'hFFFD);
    run(1, 1'b0, MODE_FREE);
    rd_timers(16'hFFFE, 16'hFFFF, 16'hFFFE);
    $display("test timers done");
    cap(4'h3);
    run(1, 1'b0, MODE_DIRECTION);
    cap(4'h2);
    repeat (3) cap(4'h8);
    rd(`CAPTURE_STATUS_ADDR, 16'hC900, 16'hFF00, 1);
    rd(`CAPTURE_DATA_ADDR0 + 16'h0001, 16'hFFFE, 16'hFFFF, 1);
    rd(`CAPTURE_DATA_ADDR0 + 16'h0001, 16'hFFFD, 16'hFFFF, 1);
    rd(`CAPTURE_DATA_ADDR0, 16'hFFFE, 16'hFFFF, 1);
    CAPTURE_EVENT = 4'h8;
    rd(`CAPTURE_DATA_ADDR0 + 16'h0003, 16'hFFFD, 16'hFFFF, 1);
    CAPTURE_EVENT = 4'h0;
    rd(`CAPTURE_STATUS_ADDR, 16'h8000, 16'hFF00, 0);
    $display("test capture done");
    for (int f = 0; f < 2; f++) begin
      act = f ? '{FORCE_HIGH, FORCE_HIGH, FORCE_HIGH} : '{FORCE_LOW, FORCE_LOW, FORCE_LOW};
      repeat (8) @(negedge CLOCK);
      check({13'h0000, PWM_A}, f ? 16'h0007 : 16'h0000);
      check({13'h0000, PWM_B}, f ? 16'h0007 : 16'h0000);
      act = '{ACTIVE_LOW, ACTIVE_HIGH, ACTIVE_HIGH};
      repeat (8) @(negedge CLOCK);
      check({13'h0000, PWM_A}, 16'h0004);
      check({13'h0000, PWM_B}, 16'h0003);
    end
    hi = 3'h0;
    COMPARE_RAW = 3'h7;
    for (int k = 0; k < 12; k++) begin
      @(negedge CLOCK);
      if (k == 1) begin
        COMPARE_RAW = 3'h5;
      end
      hi = hi | PWM_A;
    end
    check({15'h0000, hi[1]}, 16'h0000);
    check({13'h0000, PWM_B}, 16'h0003);
    DEADBAND_ON = 1'b0;
    COMPARE_RAW = 3'h7;
    repeat (2) @(negedge CLOCK);
    check({13'h0000, PWM_A}, 16'h0006);
    COMPARE_RAW = 3'h5;
    DEADBAND_ON = 1'b1;
    $display("test pwm done");
    for (int i = 0; i < 16; i++) begin
      r = lfsr_next(r);
      rd(r[0] ? (16'h7400 + {10'h000, r[7:2]}) : r, 16'h0000, 16'h0000, i != 15);
    end
    repeat (3) @(negedge CLOCK);
    $display("test random decode done");
    print_verdict();
  end
endmodule
